// file: hw/sfp_pkg.sv
// constants, types and layout for the synchronous fifo with programmable flags
// assumes a single system clock; documented pins arrive asynchronous and are resynchronised
// Function
// - storage of 64 to 8K words, 9 bits wide in and out
// - dual-enable mode: store when primary enable low and second enable high
// - both read enables low, with load high in programmable mode: next word appears at each read clock edge
// - works with read and write clocks tied or fully independent
// - empty flags move on read edges, full flags on write edges
// - every flag holds a new value at least one cycle of its clock
// - both programmable thresholds are 7 after reset
// - reset empties buffer, drives empty flag low, outputs low
// - outputs driven while output enable low, released while high
// - writes ignored when full, reads ignored when empty
// - empty buffer holds last valid read word on outputs
// - write-enable-2/load pin sampled in reset picks dual or programmable mode
// - programmable mode: primary enable low and load high store a word
// - four 8-bit offset registers: empty low/high, full low/high
// - load and primary enable low: write offsets in turn, then wrap
// - raising load keeps the offset sequence position
// - load and read enables low: read offsets in the same order
// - almost-empty low when n or fewer words remain, via one flop
// - almost-full low when words reach depth minus m, via one flop
// - almost-full high when free locations exceed m
package sfp_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH_DEFAULT = 64;
  localparam int OFFS_W = 8;
  localparam int THR_W = 2 * OFFS_W;
  localparam logic [7:0] OFFSET_DEFAULT = 8'h07;
  localparam logic [7:0] OFFSET_HI_DEFAULT = 8'h00;
  localparam logic [1:0] OFFS_AE_LO = 2'h0;
  localparam logic [1:0] OFFS_AE_HI = 2'h1;
  localparam logic [1:0] OFFS_AF_LO = 2'h2;
  localparam logic [1:0] OFFS_AF_HI = 2'h3;
  localparam int SY_WCLK = 0;
  localparam int SY_RCLK = 1;
  localparam int SY_WRITE_ENABLE_PRIMARY_N = 2;
  localparam int SY_WEN2 = 3;
  localparam int SY_RENA = 4;
  localparam int SY_RENB = 5;
  localparam int SY_RST = 6;
  localparam int SY_OE = 7;
  localparam int SY_DATA = 8;
  localparam int SYNC_W = SY_DATA + DATA_W;
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h0_00bc;
  typedef enum logic {
    SFP_MODE_PROG = 1'b0,
    SFP_MODE_DUAL = 1'b1
  } sfp_mode_t;
endpackage

// file: hw/sfp_fifo.sv
// synchronous fifo with programmable almost-empty/almost-full flags and word storage
// assumes sys_clk far faster than the pin clocks; all pins pass a two-flop synchroniser
`timescale 1ns/1ps

module sfp_store #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sfp_store_t;

  sfp_store_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign level = s_q.wp - s_q.rp;
  assign in_ready = !clear && (level < (AW+1)'(DEPTH));
  assign out_valid = !clear && (level != '0);
  assign out_data = mem[s_q.rp[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.wp = '0;
      s_d.rp = '0;
    end else begin
      if (push) begin
        s_d.wp = s_q.wp + (AW+1)'(1);
      end
      if (pop) begin
        s_d.rp = s_q.rp + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[s_q.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

module sfp_fifo #(
  parameter int DEPTH = sfp_pkg::DEPTH_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic write_clk,
  input wire logic read_clk,
  input wire logic write_enable_primary_n,
  input wire logic write_enable2_or_load,
  input wire logic read_enable_a_n,
  input wire logic read_enable_b_n,
  input wire logic fifo_reset_n,
  input wire logic output_enable_n,
  input wire logic [sfp_pkg::DATA_W-1:0] write_data,
  output logic [sfp_pkg::DATA_W-1:0] read_data,
  output logic read_data_oe,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n
);
  localparam int AW = $clog2(DEPTH);
  localparam int HI_BITS = (AW > sfp_pkg::OFFS_W) ? (AW - sfp_pkg::OFFS_W) : 0;
  localparam logic [7:0] HI_MASK = 8'((1 << HI_BITS) - 1);
  localparam logic [16:0] DEPTH_W = 17'(DEPTH);

  typedef struct packed {
    logic [sfp_pkg::SYNC_W-1:0] s1;
    logic [sfp_pkg::SYNC_W-1:0] s2;
    logic wclk_prev;
    logic rclk_prev;
    sfp_pkg::sfp_mode_t mode;
    logic [1:0] seq;
    logic [3:0][7:0] offs;
    logic empty_n;
    logic full_n;
    logic ae_n;
    logic af_n;
    logic [sfp_pkg::DATA_W-1:0] rdata;
  } sfp_state_t;

  sfp_state_t s_q, s_d;
  logic wr_edge;
  logic rd_edge;
  logic in_reset;
  logic write_enable_primary_n_low;
  logic pin2_high;
  logic ren_low;
  logic wr_cmd;
  logic rd_cmd;
  logic offs_wr;
  logic offs_rd;
  logic push;
  logic pop;
  logic st_ready;
  logic st_valid;
  logic [sfp_pkg::DATA_W-1:0] st_data;
  logic [AW:0] level;
  logic [16:0] lvl_n;
  logic [15:0] ae_thr;
  logic [15:0] af_thr;

  function automatic logic [15:0] thr(input logic [7:0] lo, input logic [7:0] hi);
    thr = {hi & HI_MASK, lo};
  endfunction

  // edges of the resampled pin clocks act as enables; tied or free clocks alike
  assign wr_edge = s_q.s2[sfp_pkg::SY_WCLK] && !s_q.wclk_prev;
  assign rd_edge = s_q.s2[sfp_pkg::SY_RCLK] && !s_q.rclk_prev;
  assign in_reset = !s_q.s2[sfp_pkg::SY_RST];
  assign write_enable_primary_n_low = !s_q.s2[sfp_pkg::SY_WRITE_ENABLE_PRIMARY_N];
  assign pin2_high = s_q.s2[sfp_pkg::SY_WEN2];
  assign ren_low = !s_q.s2[sfp_pkg::SY_RENA] && !s_q.s2[sfp_pkg::SY_RENB];
  // same store condition in both modes: pin acts as second enable or load high
  assign wr_cmd = write_enable_primary_n_low && pin2_high;
  // second enable only gates reads as load control in programmable mode
  assign rd_cmd = ren_low && (pin2_high || (s_q.mode == sfp_pkg::SFP_MODE_DUAL));
  assign offs_wr = wr_edge && !in_reset && write_enable_primary_n_low && !pin2_high
                   && (s_q.mode == sfp_pkg::SFP_MODE_PROG);
  assign offs_rd = rd_edge && !in_reset && ren_low && !pin2_high && !offs_wr
                   && (s_q.mode == sfp_pkg::SFP_MODE_PROG);
  // refused when the flag says full or empty
  assign push = wr_edge && !in_reset && wr_cmd && s_q.full_n && st_ready;
  assign pop = rd_edge && !in_reset && rd_cmd && s_q.empty_n && st_valid;
  assign ae_thr = thr(s_q.offs[sfp_pkg::OFFS_AE_LO], s_q.offs[sfp_pkg::OFFS_AE_HI]);
  assign af_thr = thr(s_q.offs[sfp_pkg::OFFS_AF_LO], s_q.offs[sfp_pkg::OFFS_AF_HI]);
  // level is formed in the one system domain, no pointer crosses a clock
  assign lvl_n = 17'(level) + 17'(push) - 17'(pop);

  sfp_store #(
    .WIDTH(sfp_pkg::DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(in_reset),
    .in_valid(push),
    .in_ready(st_ready),
    .in_data(s_q.s2[sfp_pkg::SY_DATA +: sfp_pkg::DATA_W]),
    .out_valid(st_valid),
    .out_ready(pop),
    .out_data(st_data),
    .level(level)
  );

  always_comb begin
    s_d = s_q;
    s_d.s1 = {write_data, output_enable_n, fifo_reset_n, read_enable_b_n, read_enable_a_n,
              write_enable2_or_load, write_enable_primary_n, read_clk, write_clk};
    s_d.s2 = s_q.s1;
    s_d.wclk_prev = s_q.s2[sfp_pkg::SY_WCLK];
    s_d.rclk_prev = s_q.s2[sfp_pkg::SY_RCLK];
    if (in_reset) begin
      s_d.mode = sfp_pkg::sfp_mode_t'(pin2_high);
      s_d.seq = sfp_pkg::OFFS_AE_LO;
      s_d.offs[sfp_pkg::OFFS_AE_LO] = sfp_pkg::OFFSET_DEFAULT;
      s_d.offs[sfp_pkg::OFFS_AE_HI] = sfp_pkg::OFFSET_HI_DEFAULT;
      s_d.offs[sfp_pkg::OFFS_AF_LO] = sfp_pkg::OFFSET_DEFAULT;
      s_d.offs[sfp_pkg::OFFS_AF_HI] = sfp_pkg::OFFSET_HI_DEFAULT;
      s_d.empty_n = 1'b0;
      s_d.full_n = 1'b1;
      s_d.ae_n = 1'b0;
      s_d.af_n = 1'b1;
      s_d.rdata = '0;
    end else begin
      // position is kept across load high, so the next access continues
      if (offs_wr) begin
        for (int i = 0; i < 4; i++) begin
          if (s_q.seq == 2'(i)) begin
            s_d.offs[i] = i[0] ? (s_q.s2[sfp_pkg::SY_DATA +: 8] & HI_MASK)
                               : s_q.s2[sfp_pkg::SY_DATA +: 8];
          end
        end
        s_d.seq = s_q.seq + 2'h1;
      end else if (offs_rd) begin
        s_d.rdata = {1'b0, s_q.offs[s_q.seq]};
        s_d.seq = s_q.seq + 2'h1;
      end
      // last valid word stays when reads are refused
      if (pop) begin
        s_d.rdata = st_data;
      end
      // flags move only at their own edge, so each holds a whole cycle of it
      if (rd_edge) begin
        s_d.empty_n = (lvl_n != '0);
        s_d.ae_n = (lvl_n > 17'(ae_thr));
      end
      if (wr_edge) begin
        s_d.full_n = (lvl_n != DEPTH_W);
        s_d.af_n = (lvl_n + 17'(af_thr) < DEPTH_W);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{s1: sfp_pkg::SYNC_RST, s2: sfp_pkg::SYNC_RST, wclk_prev: 1'b0, rclk_prev: 1'b0,
               mode: sfp_pkg::SFP_MODE_DUAL, seq: sfp_pkg::OFFS_AE_LO,
               offs: {sfp_pkg::OFFSET_HI_DEFAULT, sfp_pkg::OFFSET_DEFAULT,
                      sfp_pkg::OFFSET_HI_DEFAULT, sfp_pkg::OFFSET_DEFAULT},
               empty_n: 1'b0, full_n: 1'b1, ae_n: 1'b0, af_n: 1'b1, rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign read_data = s_q.rdata;
  assign read_data_oe = !s_q.s2[sfp_pkg::SY_OE];
  assign empty_flag_n = s_q.empty_n;
  assign full_flag_n = s_q.full_n;
  assign almost_empty_flag_n = s_q.ae_n;
  assign almost_full_flag_n = s_q.af_n;

  // checks
  property p_empty_moves_on_read;
    @(posedge sys_clk) disable iff (rst)
    (!$stable(empty_flag_n) && !$past(in_reset)) |-> $past(rd_edge);
  endproperty
  a_empty_moves_on_read: assert property (p_empty_moves_on_read) else $error("empty flag moved off a read edge");

  property p_full_moves_on_write;
    @(posedge sys_clk) disable iff (rst)
    (!$stable(full_flag_n) && !$past(in_reset)) |-> $past(wr_edge);
  endproperty
  a_full_moves_on_write: assert property (p_full_moves_on_write) else $error("full flag moved off a write edge");

  property p_reset_clears;
    @(posedge sys_clk) disable iff (rst)
    in_reset |=> (read_data == '0) && !empty_flag_n && (level == '0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear buffer");

  property p_default_offsets;
    @(posedge sys_clk) disable iff (rst)
    in_reset |=> (ae_thr == 16'(sfp_pkg::OFFSET_DEFAULT)) && (af_thr == 16'(sfp_pkg::OFFSET_DEFAULT));
  endproperty
  a_default_offsets: assert property (p_default_offsets) else $error("offsets not at default");

  property p_no_write_when_full;
    @(posedge sys_clk) disable iff (rst)
    (wr_edge && !full_flag_n) |-> !push;
  endproperty
  a_no_write_when_full: assert property (p_no_write_when_full) else $error("write taken while full");

  property p_hold_when_empty;
    @(posedge sys_clk) disable iff (rst)
    (rd_edge && !empty_flag_n && !offs_rd && !in_reset) |=> $stable(read_data);
  endproperty
  a_hold_when_empty: assert property (p_hold_when_empty) else $error("output changed on empty read");

  property p_almost_empty;
    @(posedge sys_clk) disable iff (rst)
    (rd_edge && !in_reset) |=> almost_empty_flag_n == ($past(lvl_n) > 17'($past(ae_thr)));
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost-empty flag wrong");

  property p_almost_full;
    @(posedge sys_clk) disable iff (rst)
    (wr_edge && !in_reset) |=> almost_full_flag_n == ($past(lvl_n) + 17'($past(af_thr)) < DEPTH_W);
  endproperty
  a_almost_full: assert property (p_almost_full) else $error("almost-full flag wrong");

  property p_offset_step;
    @(posedge sys_clk) disable iff (rst)
    offs_wr |=> s_q.seq == $past(s_q.seq) + 2'h1;
  endproperty
  a_offset_step: assert property (p_offset_step) else $error("offset sequence did not advance");

  property p_write_taken;
    @(posedge sys_clk) disable iff (rst)
    (wr_edge && !in_reset && write_enable_primary_n_low && pin2_high && full_flag_n) |-> push;
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("valid write not stored");

  property p_push_needs_enables;
    @(posedge sys_clk) disable iff (rst)
    push |-> write_enable_primary_n_low && pin2_high && full_flag_n;
  endproperty
  a_push_needs_enables: assert property (p_push_needs_enables) else $error("write without enables");

  property p_pop_needs_enables;
    @(posedge sys_clk) disable iff (rst)
    pop |-> ren_low && empty_flag_n;
  endproperty
  a_pop_needs_enables: assert property (p_pop_needs_enables) else $error("read without enables");

  property p_pop_loads_word;
    @(posedge sys_clk) disable iff (rst)
    pop |=> read_data == $past(st_data);
  endproperty
  a_pop_loads_word: assert property (p_pop_loads_word) else $error("read word not presented");

  property p_offset_read_value;
    @(posedge sys_clk) disable iff (rst)
    offs_rd |=> read_data == {1'b0, $past(s_q.offs[s_q.seq])};
  endproperty
  a_offset_read_value: assert property (p_offset_read_value) else $error("offset read value wrong");

  property p_dual_no_offsets;
    @(posedge sys_clk) disable iff (rst)
    (s_q.mode == sfp_pkg::SFP_MODE_DUAL) |-> !offs_wr && !offs_rd;
  endproperty
  a_dual_no_offsets: assert property (p_dual_no_offsets) else $error("offset access in dual mode");

  property p_mode_frozen;
    @(posedge sys_clk) disable iff (rst)
    !$past(in_reset) |-> $stable(s_q.mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed outside reset");

  property p_full_at_depth;
    @(posedge sys_clk) disable iff (rst)
    (wr_edge && !in_reset && (lvl_n == DEPTH_W)) |=> !full_flag_n;
  endproperty
  a_full_at_depth: assert property (p_full_at_depth) else $error("full flag missing at depth");

  property p_level_bound;
    @(posedge sys_clk) disable iff (rst)
    17'(level) <= DEPTH_W;
  endproperty
  a_level_bound: assert property (p_level_bound) else $error("level beyond depth");

  property p_oe_two_stage;
    @(posedge sys_clk) disable iff (rst)
    read_data_oe == !$past(s_q.s1[sfp_pkg::SY_OE]);
  endproperty
  a_oe_two_stage: assert property (p_oe_two_stage) else $error("output enable not following pin");

  property p_flags_reset;
    @(posedge sys_clk) disable iff (rst)
    in_reset |=> full_flag_n && !almost_empty_flag_n && almost_full_flag_n;
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("flags not at reset levels");

  property p_seq_held;
    @(posedge sys_clk) disable iff (rst)
    (!offs_wr && !offs_rd && !in_reset) |=> $stable(s_q.seq);
  endproperty
  a_seq_held: assert property (p_seq_held) else $error("offset position lost");

  property p_rdata_held;
    @(posedge sys_clk) disable iff (rst)
    (!pop && !offs_rd && !in_reset) |=> $stable(read_data);
  endproperty
  a_rdata_held: assert property (p_rdata_held) else $error("output changed without a read");

  property p_offset_hi_mask;
    @(posedge sys_clk) disable iff (rst)
    ((s_q.offs[sfp_pkg::OFFS_AE_HI] | s_q.offs[sfp_pkg::OFFS_AF_HI]) & ~HI_MASK) == 8'h00;
  endproperty
  a_offset_hi_mask: assert property (p_offset_hi_mask) else $error("unused offset bits set");
endmodule

// file: verification/sfp_pins.sv
// partner: producer and consumer driving the fifo pins, plus the read bus
// assumes sys_clk 200 MHz; pin clocks stand still between accesses
`timescale 1ns/1ps
module sfp_pins (
  input wire logic sys_clk,
  input wire logic [sfp_pkg::DATA_W-1:0] read_data,
  input wire logic read_data_oe,
  output logic write_clk,
  output logic read_clk,
  output logic write_enable_primary_n,
  output logic write_enable2_or_load,
  output logic read_enable_a_n,
  output logic read_enable_b_n,
  output logic fifo_reset_n,
  output logic output_enable_n,
  output logic [sfp_pkg::DATA_W-1:0] write_data,
  output logic [sfp_pkg::DATA_W-1:0] bus_data
);
  logic [sfp_pkg::DATA_W-1:0] last_q;
  initial begin
    {write_clk, read_clk, fifo_reset_n, output_enable_n} = 4'h2;
    {write_enable_primary_n, write_enable2_or_load, read_enable_a_n, read_enable_b_n} = 4'hf;
    write_data = 9'h000;
  end
  // released bus shows the inverse of the last driven word
  always @(posedge sys_clk) begin
    if (read_data_oe) begin
      last_q <= read_data;
    end
  end
  assign bus_data = read_data_oe ? read_data : ~last_q;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one pin clock per access, never a write and a read together
  task automatic pulse(input logic is_rd);
    tick(1);
    read_clk = is_rd;
    write_clk = !is_rd;
    tick(4);
    {write_clk, read_clk} = 2'b00;
    {write_enable_primary_n, write_enable2_or_load, read_enable_a_n, read_enable_b_n} = 4'hf;
    tick(4);
  endtask
  task automatic wr(input logic write_enable_primary_n_n, input logic pin2, input logic [8:0] d);
    write_enable_primary_n = write_enable_primary_n_n;
    write_enable2_or_load = pin2;
    write_data = d;
    pulse(1'b0);
  endtask
  task automatic rd(input logic a_n, input logic b_n, input logic pin2);
    read_enable_a_n = a_n;
    read_enable_b_n = b_n;
    write_enable2_or_load = pin2;
    pulse(1'b1);
  endtask
  // reset pulse with mode level, no access while low
  task automatic rst_pin(input logic mode);
    fifo_reset_n = 1'b0;
    write_enable2_or_load = mode;
    tick(8);
    fifo_reset_n = 1'b1;
    tick(4);
    write_enable2_or_load = 1'b1;
    tick(4);
  endtask
  task automatic oe(input logic v);
    output_enable_n = v;
    tick(4);
  endtask
endmodule

// file: verification/tb_top.sv
// self-checking bench for the fifo with programmable flags
// assumes sfp_pins as producer and consumer; depth 64
`timescale 1ns/1ps
module tb_top;
  logic sys_clk;
  logic rst;
  logic write_clk, read_clk, write_enable_primary_n_n, pin2, ren_a_n, ren_b_n, reset_n, oe_n;
  logic [8:0] write_data, read_data, bus_data;
  logic read_data_oe, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic [3:0] flg;
  int err_count;
  int samples_checked;
  assign flg = {empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n};
  sfp_fifo #(.DEPTH(64)) i_sfp_fifo (.sys_clk(sys_clk), .rst(rst), .write_clk(write_clk), .read_clk(read_clk),
    .write_enable_primary_n(write_enable_primary_n_n), .write_enable2_or_load(pin2), .read_enable_a_n(ren_a_n),
    .read_enable_b_n(ren_b_n), .fifo_reset_n(reset_n), .output_enable_n(oe_n), .write_data(write_data),
    .read_data(read_data), .read_data_oe(read_data_oe), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));
  sfp_pins i_sfp_pins (.sys_clk(sys_clk), .read_data(read_data), .read_data_oe(read_data_oe),
    .write_clk(write_clk), .read_clk(read_clk), .write_enable_primary_n(write_enable_primary_n_n), .write_enable2_or_load(pin2),
    .read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n), .fifo_reset_n(reset_n), .output_enable_n(oe_n),
    .write_data(write_data), .bus_data(bus_data));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_reset;
    check("flags", {5'h00, flg}, 9'h005);
    check("read_data", read_data, 9'h000);
  endtask
  task automatic t_offsets;
    logic [8:0] exp [4];
    exp = '{9'h007, 9'h000, 9'h007, 9'h000};
    for (int i = 0; i < 4; i++) begin
      i_sfp_pins.rd(1'b0, 1'b0, 1'b0);
      check("offset", bus_data, exp[i]);
    end
    i_sfp_pins.wr(1'b0, 1'b0, 9'h003);
    i_sfp_pins.tick(3);
    i_sfp_pins.wr(1'b0, 1'b0, 9'h0ff);
    i_sfp_pins.wr(1'b0, 1'b0, 9'h105);
    i_sfp_pins.wr(1'b0, 1'b0, 9'h000);
    exp = '{9'h003, 9'h000, 9'h005, 9'h000};
    for (int i = 0; i < 4; i++) begin
      i_sfp_pins.rd(1'b0, 1'b0, 1'b0);
      check("offset", bus_data, exp[i]);
    end
  endtask
  // n is 3 and m is 5 until the reset in t_dual
  task automatic t_fill;
    for (int i = 0; i < 64; i++) begin
      i_sfp_pins.wr(1'b0, 1'b1, 9'(i * 7));
      check("wflags", {5'h00, flg}, {5'h00, 1'b0, i < 63, 1'b0, i + 1 < 59});
    end
    i_sfp_pins.wr(1'b0, 1'b1, 9'h1ff);
    i_sfp_pins.rd(1'b0, 1'b0, 1'b1);
    check("first read", bus_data, 9'h000);
    check("flags", {5'h00, flg}, 9'h00a);
    for (int k = 0; k < 64; k++) begin
      if (k == 10) begin
        i_sfp_pins.rd(1'b0, 1'b1, 1'b1);
      end
      if (k == 20) begin
        i_sfp_pins.rd(1'b1, 1'b0, 1'b1);
      end
      i_sfp_pins.rd(1'b0, 1'b0, 1'b1);
      check("word", bus_data, 9'(k * 7));
      check("rflags", {5'h00, flg}, {5'h00, k < 63, 1'b0, 63 - k > 3, 1'b0});
    end
    i_sfp_pins.rd(1'b0, 1'b0, 1'b1);
    check("held word", bus_data, 9'h1b9);
  endtask
  task automatic t_dual;
    i_sfp_pins.rst_pin(1'b1);
    i_sfp_pins.wr(1'b0, 1'b0, 9'h0aa);
    i_sfp_pins.wr(1'b0, 1'b1, 9'h155);
    i_sfp_pins.rd(1'b0, 1'b0, 1'b1);
    // second write enable low must not block a read in dual mode
    i_sfp_pins.rd(1'b0, 1'b0, 1'b0);
    check("dual word", bus_data, 9'h155);
    check("empty_n", {8'h00, empty_flag_n}, 9'h000);
  endtask
  task automatic t_oe;
    i_sfp_pins.oe(1'b1);
    check("oe off", {8'h00, read_data_oe}, 9'h000);
    i_sfp_pins.oe(1'b0);
    check("oe on", {8'h00, read_data_oe}, 9'h001);
  endtask
  initial begin
    rst = 1'b1;
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    i_sfp_pins.tick(3);
    i_sfp_pins.rst_pin(1'b0);
    t_reset;
    t_offsets;
    t_fill;
    t_dual;
    t_oe;
    tally_and_finish;
  end
  // about 1400 cycles expected; cut off well beyond
  initial begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule
